//--- rtl/gtg_map.svh
`ifndef GTG_MAP_SVH
`define GTG_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define GTG_OFF_GATE_CTRL 12'h000
`define GTG_OFF_MATCH_PERIOD 12'h004
`define GTG_OFF_MATCH_COUNT 12'h008
`define GTG_OFF_TIMER_COUNT 12'h00C
`define GTG_OFF_STATUS 12'h010

// ----------------------------------------------------------------------------
// Gate control fields and reset values
// ----------------------------------------------------------------------------
`define GTG_SS_LSB 0
`define GTG_SS_MSB 1
`define GTG_TIMER_EN_BIT 4
`define GTG_TOGGLE_BIT 5
`define GTG_POL_BIT 6
`define GTG_GATE_EN_BIT 7
`define GTG_CTRL_MASK 32'h000000F3
`define GTG_CTRL_RST 8'h00
`define GTG_PERIOD_RST 8'hFF
`define GTG_ZERO8 8'h00
`define GTG_ONE8 8'h01
`define GTG_ZERO16 16'h0000
`define GTG_ONE16 16'h0001
`define GTG_STAT_VAL_BIT 0

`endif

//--- rtl/gtg_pkg.sv
package gtg_pkg;
    typedef enum logic [1:0] {
        GTG_SRC_PIN,
        GTG_SRC_MATCH,
        GTG_SRC_CMP1,
        GTG_SRC_CMP2
    } gtg_src_t;
endpackage : gtg_pkg

//--- rtl/gtg_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Two-flop level synchroniser
// ----------------------------------------------------------------------------
module gtg_sync2 (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic din,
    output logic dout
);
    logic meta_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : gtg_sync2
`default_nettype wire

//--- rtl/gtg_gate_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "gtg_map.svh"
// How it works
// [R1] The external gate pin is one of the selectable gate sources.
// [R2] The match timer counts up to its period value and returns to zero on the next increment.
// [R3] Each roll back to zero after a match gives one rising pulse into the gate logic.
// [R4] With toggling on, the selected gate drives a flip-flop that flips on every rising edge.
// [R5] With toggling on, the gated timer counts over one full cycle of the gate signal.
// [R6] Toggling is enabled by bit 5 of the gate control register.
// [R7] While toggling is off, the toggle flip-flop is cleared and held at zero.
// [R8] The gate value status bit shows the effective gate.
// [R9] Bits 1:0 pick the source: pin, match pulse, comparator 1, comparator 2.
// [R10] Bit 6 selects whether the chosen source is used as is or inverted.
// [R11] The gated timer advances only while the effective gate is high; here only with bit 7 set, as it ignores the gate when bit 7 is clear.
// [R12] Each outside source is synchronised before selection and polarity, and the adjusted source toggles on rising edges.
module gtg_gate_ctrl
    import gtg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_gate_pin,
    input wire logic cmp1_out,
    input wire logic cmp2_out,
    input wire logic match_tick,
    input wire logic timer_tick,
    output logic gate_value_status,
    output logic timer_count_en,
    output logic match_pulse
);
    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    logic [7:0] gate_control_reg_r;
    logic [7:0] match_period_value_r;
    logic [7:0] match_timer_count_r;
    logic [15:0] gated_timer_r;
    logic gate_eff;

    wire acc = psel && penable;
    wire wr_en = acc && pwrite;
    wire sel_ctrl = paddr == `GTG_OFF_GATE_CTRL;
    wire sel_per = paddr == `GTG_OFF_MATCH_PERIOD;
    wire sel_cnt = paddr == `GTG_OFF_MATCH_COUNT;
    wire sel_tmr = paddr == `GTG_OFF_TIMER_COUNT;
    wire sel_stat = paddr == `GTG_OFF_STATUS;
    wire mapped = sel_ctrl | sel_per | sel_cnt | sel_tmr | sel_stat;
    wire [31:0] rd_mux = sel_ctrl ? {24'h000000, gate_control_reg_r} :
                         sel_per ? {24'h000000, match_period_value_r} :
                         sel_cnt ? {24'h000000, match_timer_count_r} :
                         sel_tmr ? {16'h0000, gated_timer_r} :
                         sel_stat ? {31'h0, gate_eff} : 32'h00000000;

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gate_control_reg_r <= `GTG_CTRL_RST;
            match_period_value_r <= `GTG_PERIOD_RST;
        end else if (wr_en && sel_ctrl) begin
            gate_control_reg_r <= 8'(pwdata & `GTG_CTRL_MASK); // [R6] [R9] [R10]
        end else if (wr_en && sel_per) begin
            match_period_value_r <= pwdata[7:0];
        end
    end

    wire toggle_enable = gate_control_reg_r[`GTG_TOGGLE_BIT];
    wire gate_polarity_select = gate_control_reg_r[`GTG_POL_BIT];
    wire gate_en = gate_control_reg_r[`GTG_GATE_EN_BIT];
    wire timer_en = gate_control_reg_r[`GTG_TIMER_EN_BIT];
    wire [1:0] gate_source_select =
        gate_control_reg_r[`GTG_SS_MSB:`GTG_SS_LSB];

    // ------------------------------------------------------------------------
    // Match timer
    // ------------------------------------------------------------------------
    // A software write to the count wins over an increment in that cycle.
    wire at_match = match_timer_count_r == match_period_value_r;
    logic [7:0] match_nxt;
    assign match_nxt = at_match ? `GTG_ZERO8 :
                       8'(match_timer_count_r + `GTG_ONE8); // [R2]

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            match_timer_count_r <= `GTG_ZERO8;
            match_pulse <= 1'b0;
        end else begin
            match_pulse <= match_tick && at_match &&
                           !(wr_en && sel_cnt); // [R3]
            if (wr_en && sel_cnt) begin
                match_timer_count_r <= pwdata[7:0];
            end else if (match_tick) begin
                match_timer_count_r <= match_nxt; // [R2]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Gate source, polarity and synchronisation
    // ------------------------------------------------------------------------
    // Each outside gate passes its own two flops before the selector: a mux
    // in front of one shared synchroniser could glitch into it on a switch.
    // The match pulse is already on this clock and goes straight through.
    logic pin_sync;
    logic cmp1_sync;
    logic cmp2_sync;
    gtg_sync2 u_sync_pin (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(ext_gate_pin),
        .dout(pin_sync)
    ); // [R1] [R12]
    gtg_sync2 u_sync_cmp1 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(cmp1_out),
        .dout(cmp1_sync)
    ); // [R12]
    gtg_sync2 u_sync_cmp2 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(cmp2_out),
        .dout(cmp2_sync)
    ); // [R12]

    gtg_src_t src;
    assign src = gtg_src_t'(gate_source_select);
    logic src_raw;
    always_comb begin
        unique case (src)
            GTG_SRC_PIN: src_raw = pin_sync; // [R1] [R9]
            GTG_SRC_MATCH: src_raw = match_pulse; // [R3] [R9]
            GTG_SRC_CMP1: src_raw = cmp1_sync; // [R9]
            GTG_SRC_CMP2: src_raw = cmp2_sync; // [R9]
        endcase
    end

    // A change of source or polarity can itself look like a rising edge, so
    // software should set both before it enables toggling.
    wire src_pol = src_raw ^ gate_polarity_select; // [R10]

    logic src_prev_r;
    logic toggle_r;
    wire rise = src_pol && !src_prev_r; // [R12]

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            src_prev_r <= 1'b0;
            toggle_r <= 1'b0;
        end else begin
            src_prev_r <= src_pol;
            if (!toggle_enable) begin
                toggle_r <= 1'b0; // [R7]
            end else if (rise) begin
                toggle_r <= !toggle_r; // [R4] [R5]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Effective gate and gated timer
    // ------------------------------------------------------------------------
    assign gate_eff = toggle_enable ? toggle_r : src_pol; // [R4] [R11]
    assign gate_value_status = gate_eff; // [R8]
    assign timer_count_en = timer_en && (!gate_en || gate_eff) &&
                            timer_tick; // [R11]

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gated_timer_r <= `GTG_ZERO16;
        end else if (wr_en && sel_tmr) begin
            gated_timer_r <= pwdata[15:0];
        end else if (timer_count_en) begin
            gated_timer_r <= 16'(gated_timer_r + `GTG_ONE16); // [R11] [R5]
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_match_wrap: assert property ( // [R2]
        match_tick && at_match && !(wr_en && sel_cnt)
        |=> match_timer_count_r == `GTG_ZERO8)
        else $error("match count did not wrap");
    a_match_pulse: assert property ( // [R3]
        match_pulse |-> $past(at_match) && $past(match_tick)
        && !$past(wr_en && sel_cnt))
        else $error("match pulse without wrap");
    a_toggle_hold: assert property (!toggle_enable |=> !toggle_r) // [R7]
        else $error("toggle not held clear");
    a_toggle_flip: assert property ( // [R4]
        toggle_enable && rise |=> toggle_r != $past(toggle_r))
        else $error("toggle missed edge");
    a_toggle_keep: assert property ( // [R12]
        toggle_enable && !rise |=> $stable(toggle_r))
        else $error("toggle changed without edge");
    // The synchronisers restart from zero, so the path checks wait until
    // two clean edges have passed since reset.
    a_pin_path: assert property ( // [R1]
        src == GTG_SRC_PIN && !toggle_enable && !$past(sys_rst)
        && !$past(sys_rst, 2) |-> gate_value_status ==
        ($past(ext_gate_pin, 2) ^ gate_polarity_select))
        else $error("pin gate path wrong");
    a_status_gate: assert property ( // [R8]
        src == GTG_SRC_CMP2 && !toggle_enable && !$past(sys_rst)
        && !$past(sys_rst, 2) |-> gate_value_status ==
        ($past(cmp2_out, 2) ^ gate_polarity_select))
        else $error("status differs from gate");
    a_timer_gated: assert property ( // [R11]
        timer_en && gate_en && !gate_eff && !(wr_en && sel_tmr)
        |=> $stable(gated_timer_r))
        else $error("timer counted with gate closed");
    a_ctrl_write: assert property ( // [R6]
        wr_en && sel_ctrl |=>
        toggle_enable == $past(pwdata[`GTG_TOGGLE_BIT]))
        else $error("toggle enable not written");
    a_polarity: assert property ( // [R10]
        src == GTG_SRC_CMP1 && !toggle_enable && !$past(sys_rst)
        && !$past(sys_rst, 2) |-> gate_value_status ==
        ($past(cmp1_out, 2) ^ gate_polarity_select))
        else $error("polarity wrong");

    c_wrap: cover property (match_pulse);
    c_toggle: cover property (toggle_enable && rise ##1 toggle_r);
    c_count: cover property (timer_count_en && toggle_enable);
    c_slverr: cover property (pslverr);
    c_match_gate: cover property (src == GTG_SRC_MATCH && toggle_enable
        && rise);
endmodule : gtg_gate_ctrl
`default_nettype wire

//--- verif/gtg_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Gate source model
// ----------------------------------------------------------------------------
// The sources that are not selected show the inverse level, so that a wrong
// selection can never pass unseen.
module gtg_src_model
    import gtg_pkg::*;
(
    input wire logic [1:0] sel,
    input wire logic level,
    output logic ext_gate_pin,
    output logic cmp1_out,
    output logic cmp2_out
);
    assign ext_gate_pin = (sel == GTG_SRC_PIN) ? level : ~level;
    assign cmp1_out = (sel == GTG_SRC_CMP1) ? level : ~level;
    assign cmp2_out = (sel == GTG_SRC_CMP2) ? level : ~level;
endmodule : gtg_src_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gtg_map.svh"
module tb_top
    import gtg_pkg::*;
;
    logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic match_tick = 0, timer_tick = 0, lvl = 0;
    logic [1:0] sel = 2'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, pin, c1, c2, gv, ten, mp;
    logic [32:0] expq[$];
    int n_mismatch = 0, n_tests = 0, n_pulse = 0, n_cnt = 0, per;

    always #5 mclk = ~mclk;

    gtg_gate_ctrl dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_gate_pin(pin), .cmp1_out(c1), .cmp2_out(c2),
        .match_tick(match_tick), .timer_tick(timer_tick),
        .gate_value_status(gv), .timer_count_en(ten), .match_pulse(mp));
    gtg_src_model model (.sel(sel), .level(lvl), .ext_gate_pin(pin),
        .cmp1_out(c1), .cmp2_out(c2));

    // ------------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------------
    task chk(input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t exp %h got %h", $time, e, g);
        end
    endtask : chk

    task give_verdict;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (expq.size() == 0) chk(33'h0, 33'h1_FFFF_FFFF);
            else if (pwrite) chk(expq[0], {pslverr, expq[0][31:0]});
            else chk(expq[0], {pslverr, prdata});
            if (expq.size() != 0 && !pwrite && paddr == `GTG_OFF_STATUS)
                chk({32'h0, expq[0][0]}, {32'h0, gv});
            if (expq.size() != 0) void'(expq.pop_front());
        end
        if (mp === 1'b1) n_pulse++;
        if (ten === 1'b1) n_cnt++;
    end

    // ------------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------------
    // The release idles one cycle so that psel is never set twice in a step.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v,
             input logic [32:0] e);
        int k;
        expq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) n_mismatch++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task gate(input logic l);
        lvl <= l;
        repeat (4) @(posedge mclk);
    endtask : gate

    task st(input logic v);
        apb(1'b0, `GTG_OFF_STATUS, 32'h0, {32'h0, v});
    endtask : st

    task tick(input int n);
        timer_tick <= 1'b1;
        repeat (n) @(posedge mclk);
        timer_tick <= 1'b0;
        @(posedge mclk);
    endtask : tick

    initial begin
        void'($urandom(32'h1F3627CE));
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        apb(1'b0, `GTG_OFF_GATE_CTRL, 32'h0, 33'h0);
        apb(1'b0, `GTG_OFF_MATCH_PERIOD, 32'h0, {25'h0, `GTG_PERIOD_RST});
        st(1'b0);
        apb(1'b0, 12'h0FC, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h0FC, 32'h1, {1'b1, 32'h0});
        d = $urandom;
        apb(1'b1, `GTG_OFF_GATE_CTRL, d, {1'b0, d});
        apb(1'b0, `GTG_OFF_GATE_CTRL, 32'h0, {1'b0, d & `GTG_CTRL_MASK});
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2 && s != 1; p++) begin
                sel <= s[1:0];
                d = {24'h0, 1'b1, p[0], 2'b01, 2'b00, s[1:0]};
                apb(1'b1, `GTG_OFF_GATE_CTRL, d, {1'b0, d});
                gate(1'b1);
                st(~p[0]);
                gate(1'b0);
                st(p[0]);
            end
        end
        sel <= GTG_SRC_PIN;
        apb(1'b1, `GTG_OFF_GATE_CTRL, 32'h90, 33'h90);
        apb(1'b1, `GTG_OFF_TIMER_COUNT, 32'h0, 33'h0);
        n_cnt = 0;
        tick(10);
        chk(33'h0, 33'(n_cnt));
        apb(1'b0, `GTG_OFF_TIMER_COUNT, 32'h0, 33'h0);
        gate(1'b1);
        n_cnt = 0;
        tick(10);
        chk(33'h0A, 33'(n_cnt));
        apb(1'b0, `GTG_OFF_TIMER_COUNT, 32'h0, 33'h0A);
        gate(1'b0);
        apb(1'b1, `GTG_OFF_GATE_CTRL, 32'hB0, 33'hB0);
        st(1'b0);
        gate(1'b1);
        st(1'b1);
        gate(1'b0);
        st(1'b1);
        gate(1'b1);
        st(1'b0);
        apb(1'b1, `GTG_OFF_GATE_CTRL, 32'h90, 33'h90);
        apb(1'b1, `GTG_OFF_GATE_CTRL, 32'hB0, 33'hB0);
        gate(1'b1);
        st(1'b0);
        per = $urandom_range(6, 1);
        apb(1'b1, `GTG_OFF_MATCH_PERIOD, 32'(per), 33'(per));
        n_pulse = 0;
        match_tick <= 1'b1;
        repeat (20) @(posedge mclk);
        match_tick <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(33'(20 / (per + 1)), 33'(n_pulse));
        apb(1'b0, `GTG_OFF_MATCH_COUNT, 32'h0, 33'(20 % (per + 1)));
        // One wrap of the match timer must flip the toggle once.
        apb(1'b1, `GTG_OFF_MATCH_COUNT, 32'h0, 33'h0);
        apb(1'b1, `GTG_OFF_GATE_CTRL, 32'hB1, 33'hB1);
        st(1'b0);
        match_tick <= 1'b1;
        repeat (per + 1) @(posedge mclk);
        match_tick <= 1'b0;
        repeat (2) @(posedge mclk);
        st(1'b1);
        give_verdict;
    end

    initial begin
        #200000;
        n_mismatch++;
        give_verdict;
    end
endmodule : tb_top
`default_nettype wire
